// ### rtl/btc_buzzer_tone.v
// Buzzer tone generator with burst timer, user byte and config checksum,
// reached over a two-wire target port. Assumes scl/sda come from pins in
// another timing domain; sda is open drain, pulled low while sda_oe is high.
`include "btc_consts.vh"

module btc_buzzer_tone #(
    parameter [6:0]  TARGET_ADDR = 7'h37,              // Arbitrary bus address
    parameter        STEP_CYC    = `BTC_TONE_STEP_CYC,
    parameter        SCAN_CYC    = `BTC_SCAN_CYC
) (
    input  wire        core_clk,
    input  wire        reset,
    input  wire        scl_in,
    input  wire        sda_in,
    output wire        sda_out,
    output reg         sda_oe,
    input  wire        tone_trigger,
    output reg         tone_out_first,
    output reg         tone_out_second,
    output reg         tone_active,
    output reg  [7:0]  host_user_byte,
    output reg  [15:0] config_sum,
    output reg         config_sum_ok
);

    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    reg scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;

    // Three flops per pin; edge logic only looks at the second and later
    always @(posedge core_clk) begin
        if (reset) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_p <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            scl_p <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_p <= sda_s;
        end
    end

    wire scl_rise = scl_s & ~scl_p;
    wire scl_fall = ~scl_s & scl_p;
    wire bus_start = scl_s & scl_p & sda_p & ~sda_s;
    wire bus_stop  = scl_s & scl_p & ~sda_p & sda_s;
    assign sda_out = 1'b0;                        // Open drain: only ever pulls low

    // ****************************************************************
    // Register storage
    // ****************************************************************
    reg  [7:0] regs [0:31];
    reg        reg_we;
    reg  [4:0] reg_widx;
    reg  [7:0] reg_wdata;
    integer    i;
    integer    j;

    // Every offset is plain host storage; the block reads its fields directly
    always @(posedge core_clk) begin
        if (reset) begin
            for (i = 0; i < 32; i = i + 1) begin
                regs[i] <= `BTC_RST_BYTE;
            end
            regs[`BTC_OFS_SUM_LOW] <= `BTC_RST_SUM_LOW;
        end else if (reg_we) begin
            regs[reg_widx] <= reg_wdata;
        end
    end

    wire [7:0] cfg      = regs[`BTC_OFS_TONE_CFG];
    wire [2:0] freq_sel = cfg[`BTC_CFG_FREQ_MSB:0];
    wire       tone_en  = cfg[`BTC_CFG_EN_BIT];
    wire       two_pins = cfg[`BTC_CFG_PINS_BIT];
    wire       rest_lvl = cfg[`BTC_CFG_IDLE_BIT];
    wire [6:0] burst_len = regs[`BTC_OFS_DURATION][`BTC_DUR_MSB:0];
    wire       led_mode = regs[`BTC_OFS_MODE][`BTC_MODE_LED_BIT];

    // ****************************************************************
    // Configuration checksum
    // ****************************************************************
    reg  [15:0] next_sum;
    reg  [4:0]  sum_last;

    // Range end depends on mode; device mode leaves the sum bytes out
    always @* begin
        next_sum = 16'h0000;
        sum_last = led_mode ? `BTC_SUM_LAST_LED : `BTC_SUM_LAST_DEV;
        for (j = `BTC_SUM_FIRST; j < 32; j = j + 1) begin
            if (j[4:0] <= sum_last) begin
                next_sum = next_sum + {8'h00, regs[j]};
            end
        end
    end

    // Registered so the adder tree is off the output path
    always @(posedge core_clk) begin
        if (reset) begin
            config_sum     <= 16'h0000;
            config_sum_ok  <= 1'b0;
            host_user_byte <= `BTC_RST_BYTE;
        end else begin
            config_sum     <= next_sum;
            config_sum_ok  <= (next_sum == {regs[`BTC_OFS_SUM_HIGH], regs[`BTC_OFS_SUM_LOW]});
            host_user_byte <= regs[`BTC_OFS_USER_BYTE];
        end
    end

    // ****************************************************************
    // Two-wire target state machine
    // ****************************************************************
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_RX   = 3'd1;
    localparam [2:0] S_RACK = 3'd2;
    localparam [2:0] S_TX   = 3'd3;
    localparam [2:0] S_TACK = 3'd4;

    reg [2:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shift;
    reg [1:0] phase;      // 0 address, 1 pointer, 2 data
    reg       is_read;
    reg       nack;
    reg [4:0] ptr;

    // Bits are sampled on scl rise and driven on scl fall
    always @(posedge core_clk) begin
        reg_we <= 1'b0;
        if (reset) begin
            state     <= S_IDLE;
            bit_cnt   <= 4'h0;
            shift     <= 8'h00;
            phase     <= 2'd0;
            is_read   <= 1'b0;
            nack      <= 1'b0;
            ptr       <= 5'h00;
            sda_oe    <= 1'b0;
            reg_widx  <= 5'h00;
            reg_wdata <= 8'h00;
        end else if (bus_start) begin
            state   <= S_RX;
            bit_cnt <= 4'h0;
            phase   <= 2'd0;
            sda_oe  <= 1'b0;
        end else if (bus_stop) begin
            state  <= S_IDLE;
            sda_oe <= 1'b0;
        end else begin
            case (state)
                S_RX: begin
                    if (scl_rise) begin
                        shift   <= {shift[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        state   <= S_RACK;
                        sda_oe  <= 1'b1;
                        if (phase == 2'd0) begin
                            is_read <= shift[0];
                            phase   <= 2'd1;
                            if (shift[7:1] != TARGET_ADDR) begin
                                state  <= S_IDLE;
                                sda_oe <= 1'b0;
                            end
                        end else if (phase == 2'd1) begin
                            ptr   <= shift[4:0];
                            phase <= 2'd2;
                        end else begin
                            reg_we    <= 1'b1;
                            reg_widx  <= ptr;
                            reg_wdata <= shift;
                            ptr       <= ptr + 5'h01;
                        end
                    end
                end
                S_RACK: begin
                    if (scl_fall) begin
                        if (is_read) begin
                            state  <= S_TX;
                            shift  <= regs[ptr];
                            sda_oe <= ~regs[ptr][7];
                            ptr    <= ptr + 5'h01;
                        end else begin
                            state  <= S_RX;
                            sda_oe <= 1'b0;
                        end
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == 4'h7) begin
                            bit_cnt <= 4'h0;
                            sda_oe  <= 1'b0;          // Release for controller ack
                            state   <= S_TACK;
                        end else begin
                            shift  <= {shift[6:0], 1'b0};
                            sda_oe <= ~shift[6];
                        end
                    end
                end
                S_TACK: begin
                    if (scl_rise) begin
                        nack <= sda_s;
                    end else if (scl_fall) begin
                        if (nack) begin
                            state <= S_IDLE;
                        end else begin
                            state  <= S_TX;
                            shift  <= regs[ptr];
                            sda_oe <= ~regs[ptr][7];
                            ptr    <= ptr + 5'h01;
                        end
                    end
                end
                default: begin
                    state  <= S_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Tone generator and burst timer
    // ****************************************************************
    localparam STEP_W = 24;
    localparam SCAN_W = 32;

    reg [STEP_W-1:0] step_cnt;
    reg [SCAN_W-1:0] scan_cnt;
    reg [2:0]        unit_cnt;
    reg [6:0]        scans_left;
    wire             step_tick = (step_cnt == STEP_CYC - 1);
    wire             scan_tick = (scan_cnt == SCAN_CYC - 1);

    // Tone period and high time in 125 us steps
    wire [2:0] period_units = (freq_sel < 3'd2) ? 3'd1 : freq_sel;        // minus one
    wire [3:0] high_sum     = {1'b0, freq_sel} + 4'd2;
    wire [2:0] high_units   = high_sum[3:1];
    wire       wave_high    = (unit_cnt < high_units);

    // Zero duration never starts a burst, guarding a host that breaks the range
    always @(posedge core_clk) begin
        if (reset) begin
            tone_active <= 1'b0;
            step_cnt    <= {STEP_W{1'b0}};
            scan_cnt    <= {SCAN_W{1'b0}};
            unit_cnt    <= 3'd0;
            scans_left  <= 7'd0;
        end else if (!tone_en) begin
            tone_active <= 1'b0;
        end else if (tone_trigger && burst_len != 7'd0) begin
            tone_active <= 1'b1;
            scans_left  <= burst_len;
            step_cnt    <= {STEP_W{1'b0}};
            scan_cnt    <= {SCAN_W{1'b0}};
            unit_cnt    <= 3'd0;
        end else if (tone_active) begin
            step_cnt <= step_tick ? {STEP_W{1'b0}} : step_cnt + 1'b1;
            scan_cnt <= scan_tick ? {SCAN_W{1'b0}} : scan_cnt + 1'b1;
            if (step_tick) begin
                unit_cnt <= (unit_cnt >= period_units) ? 3'd0 : unit_cnt + 3'd1;
            end
            if (scan_tick) begin
                scans_left <= scans_left - 7'd1;
                if (scans_left == 7'd1) begin
                    tone_active <= 1'b0;
                end
            end
        end
    end

    // Outputs registered; in a burst the second pin mirrors the first in antiphase
    always @(posedge core_clk) begin
        if (reset) begin
            tone_out_first  <= 1'b0;
            tone_out_second <= 1'b0;
        end else if (!tone_active) begin
            tone_out_first  <= rest_lvl;
            tone_out_second <= two_pins & rest_lvl;
        end else begin
            tone_out_first  <= rest_lvl ^ wave_high;
            tone_out_second <= two_pins & ~(rest_lvl ^ wave_high);
        end
    end

endmodule

// ### rtl/btc_consts.vh
// Constants for the buzzer tone and configuration checksum block.
// Assumes a 100 MHz core clock and a byte-wide register map of 32 entries.
//
// Notes on behaviour
// - Three-bit code picks tone frequency and duty
// - Pin setting selects one or two outputs
// - First output rests at configured idle level
// - Burst lasts duration times scan period
// - Free user byte, kept for storage
// - LED mode checksum sums offsets 0x01-0x1F
// - Device mode checksum sums offsets 0x01-0x1D
`ifndef BTC_CONSTS_VH
`define BTC_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define BTC_OFS_MODE        5'h00
`define BTC_OFS_TONE_CFG    5'h1b
`define BTC_OFS_DURATION    5'h1c
`define BTC_OFS_USER_BYTE   5'h1d
`define BTC_OFS_SUM_HIGH    5'h1e
`define BTC_OFS_SUM_LOW     5'h1f
`define BTC_SUM_FIRST       5'h01
`define BTC_SUM_LAST_LED    5'h1f
`define BTC_SUM_LAST_DEV    5'h1d

// ****************************************************************
// Field positions
// ****************************************************************
`define BTC_MODE_LED_BIT    0
`define BTC_CFG_EN_BIT      7
`define BTC_CFG_PINS_BIT    6
`define BTC_CFG_IDLE_BIT    5
`define BTC_CFG_FREQ_MSB    2
`define BTC_DUR_MSB         6

// ****************************************************************
// Reset values
// ****************************************************************
`define BTC_RST_BYTE        8'h00
`define BTC_RST_SUM_LOW     8'h3b

// ****************************************************************
// Timing: tone step of 125 us, all tones are whole steps
// ****************************************************************
`define BTC_CLK_PERIOD_NS   10
`define BTC_TONE_STEP_NS    125000
`define BTC_TONE_STEP_CYC   (`BTC_TONE_STEP_NS / `BTC_CLK_PERIOD_NS)
`define BTC_SCAN_PERIOD_NS  16000000
`define BTC_SCAN_CYC        (`BTC_SCAN_PERIOD_NS / `BTC_CLK_PERIOD_NS)

`endif

// ### verif/btc_buzzer_model.sv
// Model of an AC buzzer on one or two pins: counts what it is driven with.
// Assumes the bench pulses clear at each trigger and names the rest level.
module btc_buzzer_model (
    input  wire        core_clk,
    input  wire        clear,
    input  wire        rest,
    input  wire        active,
    input  wire        pin_a,
    input  wire        pin_b,
    output reg  [15:0] hi_cnt,
    output reg  [15:0] b_cnt,
    output reg  [15:0] on_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    // A voltage across the part only exists while the two ends differ
    always @(posedge core_clk) begin
        if (clear) begin
            hi_cnt <= 16'h0000;
            b_cnt  <= 16'h0000;
            on_cnt <= 16'h0000;
        end else begin
            if (pin_a !== rest) hi_cnt <= hi_cnt + 16'h0001;
            if (pin_a !== pin_b) b_cnt <= b_cnt + 16'h0001;
            if (active === 1'b1) on_cnt <= on_cnt + 16'h0001;
        end
    end
endmodule

// ### verif/btc_buzzer_tone_assertions.sv
// Checker for the buzzer tone block, bound to its top module.
// Assumes the bench sets STEP_CYC to 4; the burst figures follow it.
module btc_buzzer_tone_assertions #(
    parameter STEP_CYC = 4,
    parameter SCAN_CYC = 40
) (
    input logic        core_clk,
    input logic        reset,
    input logic        scl_in,
    input logic        sda_in,
    input logic        sda_out,
    input logic        sda_oe,
    input logic        tone_trigger,
    input logic        tone_out_first,
    input logic        tone_out_second,
    input logic        tone_active,
    input logic [7:0]  host_user_byte,
    input logic [15:0] config_sum,
    input logic        config_sum_ok
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] hold;
    logic        prev_a;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // Cycles since the first pin last moved; saturates so long idles stay safe
    always @(posedge core_clk) begin
        prev_a <= tone_out_first;
        if (reset || tone_out_first != prev_a) hold <= 16'h0000;
        else if (hold != 16'hffff) hold <= hold + 16'h0001;
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    sequence s_launch;
        $rose(tone_active) ##1 $changed(tone_out_first);
    endsequence
    sequence s_over;
        $fell(tone_active) ##1 !tone_active;
    endsequence
    a_sda_open_drain: assert property (sda_out == 1'b0)
        else $error("sda value not held low");
    // Reset itself is the antecedent, so this one must not be switched off by it
    a_reset_quiet: assert property (disable iff (1'b0) $past(reset) |-> !tone_active
        && !sda_oe && host_user_byte == 8'h00)
        else $error("outputs not quiet after reset");
    a_start_cause: assert property ($rose(tone_active) |-> $past(tone_trigger))
        else $error("burst began without a trigger");
    a_first_swing: assert property ($rose(tone_active) |-> s_launch)
        else $error("first pin did not leave rest at burst start");
    a_idle_hold: assert property (s_over |=> $stable(tone_out_first)[*4])
        else $error("first pin moved after burst end");
    a_pins_opposed: assert property (tone_active && $past(tone_active) && tone_out_second
        |-> tone_out_second != tone_out_first)
        else $error("two pins drive the same level");
    // Idle second pin either follows the first or stays low, never a DC step
    a_idle_no_dc: assert property (!tone_active && $past(!tone_active)
        |-> !(tone_out_second && !tone_out_first))
        else $error("second pin high while first rests low");
    a_step_hold: assert property (tone_active && $past(tone_active) && $changed(tone_out_first)
        |-> hold >= STEP_CYC - 1)
        else $error("tone edge closer than one step");
    a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("data pulled low while clock high");
endmodule
bind btc_buzzer_tone btc_buzzer_tone_assertions #(.STEP_CYC(STEP_CYC), .SCAN_CYC(SCAN_CYC))
    btc_buzzer_tone_assertions_i (.core_clk, .reset, .scl_in, .sda_in, .sda_out, .sda_oe,
    .tone_trigger, .tone_out_first, .tone_out_second, .tone_active, .host_user_byte,
    .config_sum, .config_sum_ok);

// ### verif/tb_top.sv
// Bench for the buzzer tone block: two-wire register access and bursts.
// Assumes a pull-up on the data pin and short step and scan parameters.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam [6:0] ADR = 7'h37;
    logic        core_clk, reset, scl, sd_lo, trig, clr, rest, k;
    logic [7:0]  q;
    int          n_fail, tests_run;
    int          cyc = 0;
    wire         sda_out, sda_oe, tone_out_first, tone_out_second, tone_active;
    wire         config_sum_ok;
    wire [7:0]   host_user_byte;
    wire [15:0]  config_sum, hi_cnt, b_cnt, on_cnt;
    wire         sda = !(sda_oe || sd_lo); // Pull-up unless someone pulls low
    btc_buzzer_tone #(.STEP_CYC(4), .SCAN_CYC(40)) btc_buzzer_tone_i (.core_clk, .reset,
        .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .tone_trigger(trig), .tone_out_first,
        .tone_out_second, .tone_active, .host_user_byte, .config_sum, .config_sum_ok);
    btc_buzzer_model btc_buzzer_model_i (.core_clk, .clear(clr), .rest, .active(tone_active),
        .pin_a(tone_out_first), .pin_b(tone_out_second), .hi_cnt, .b_cnt, .on_cnt);
    // ****************************************************************
    // Access tasks
    // ****************************************************************
    task automatic tk(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input logic [15:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic summarize;
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Data moves only mid-low, so the synchronisers never see a false start
    task automatic bit_io(input logic b, output logic r);
        sd_lo <= !b;
        tk(6);
        scl <= 1'b1;
        tk(12);
        r = sda;
        scl <= 1'b0;
        tk(6);
    endtask
    task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] o, output logic a);
        for (int i = 7; i >= 0; i--) bit_io(d[i], o[i]);
        bit_io(m, a);
    endtask
    task automatic edge2(input logic s);
        sd_lo <= s;
        tk(6);
        scl <= 1'b1;
        tk(6);
        sd_lo <= !s;
        tk(6);
        scl <= s ? 1'b1 : 1'b0;
        tk(6);
    endtask
    task automatic wr(input logic [7:0] a, d);
        logic [7:0] o;
        logic a0, a1, a2;
        edge2(1'b0);
        xfer({ADR, 1'b0}, 1'b1, o, a0);
        xfer(a, 1'b1, o, a1);
        xfer(d, 1'b1, o, a2);
        edge2(1'b1);
        chk({13'h0, a0, a1, a2}, 16'h0000);
    endtask
    task automatic rchk(input logic [7:0] a, e);
        logic [7:0] o;
        logic a0, a1, a2, a3;
        edge2(1'b0);
        xfer({ADR, 1'b0}, 1'b1, o, a0);
        xfer(a, 1'b1, o, a1);
        edge2(1'b0);
        xfer({ADR, 1'b1}, 1'b1, o, a2);
        xfer(8'hff, 1'b1, o, a3);
        edge2(1'b1);
        chk({13'h0, a0, a1, a2}, 16'h0000);
        chk({8'h00, o}, {8'h00, e});
    endtask
    task automatic pulse;
        clr <= 1'b1;
        trig <= 1'b1;
        tk(1);
        clr <= 1'b0;
        trig <= 1'b0;
        tk(3);
    endtask
    // One burst, then the model's counts against the step table
    task automatic burst(input logic [7:0] cfg, dur);
        int p, h, e;
        wr(8'h1c, dur);
        wr(8'h1b, cfg);
        rest <= cfg[5];
        pulse();
        for (e = 0; e < 9000 && tone_active === 1'b1; e++) tk(1);
        tk(4);
        p = (cfg[2:0] == 3'd0) ? 2 : int'(cfg[2:0]) + 1;
        h = (p + 1) / 2;
        e = 0;
        for (int s = 0; s < 10 * dur; s++) e += (s % p < h) ? 4 : 0;
        chk(hi_cnt, 16'(e));
        chk(on_cnt, 16'(40 * dur));
        chk(b_cnt, cfg[6] ? 16'(40 * dur) : 16'(e));
        chk({14'h0, tone_out_first, tone_out_second}, {14'h0, cfg[5], cfg[5] & cfg[6]});
        $display("Tone test %h done", cfg);
    endtask
    // ****************************************************************
    // Clock, timeout and test sequence
    // ****************************************************************
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Ceiling well above the roughly 25k cycles the tests need
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        {reset, scl, sd_lo, trig, clr, rest} = 6'b110000;
        n_fail = 0;
        tests_run = 0;
        tk(20);
        reset <= 1'b0;
        tk(4);
        chk(config_sum, 16'h0000);
        rchk(8'h1c, 8'h00);
        rchk(8'h1d, 8'h00);
        rchk(8'h1e, 8'h00);
        rchk(8'h1f, 8'h3b);
        wr(8'h00, 8'h01);
        chk(config_sum, 16'h003b);
        chk(16'(config_sum_ok), 16'h0001);
        wr(8'h1d, 8'ha5);
        rchk(8'h1d, 8'ha5);
        chk({8'h00, host_user_byte}, 16'h00a5);
        chk(config_sum, 16'h00e0);
        chk(16'(config_sum_ok), 16'h0000);
        wr(8'h00, 8'h00);
        chk(config_sum, 16'h00a5);
        edge2(1'b0);
        xfer({7'h12, 1'b0}, 1'b1, q, k);
        edge2(1'b1);
        chk(16'(k), 16'h0001);
        $display("Register test done");
        for (int c = 0; c < 8; c++) burst(8'h80 | 8'(c), 8'h01);
        burst(8'he3, 8'h02);
        burst(8'hc5, 8'h01);
        wr(8'h1c, 8'h7f);
        wr(8'h1b, 8'h81);
        pulse();
        tk(50);
        wr(8'h1b, 8'h01);
        chk({15'h0, tone_active}, 16'h0000);
        chk({15'h0, tone_out_first}, 16'h0000);
        pulse();
        chk({15'h0, tone_active}, 16'h0000);
        // A zero duration while enabled must never start a burst
        wr(8'h1c, 8'h00);
        wr(8'h1b, 8'h81);
        pulse();
        chk({15'h0, tone_active}, 16'h0000);
        $display("Abort test done");
        summarize();
    end
endmodule
